// [iocc_fifo.v]
// Parameterised valid/ready FIFO
`timescale 1ns/10ps
`default_nettype none
module iocc_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire sys_rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;
  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
  always @(posedge clk) begin
    if (sys_rst) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // iocc_fifo
`default_nettype wire

// [iocc_map.vh]
// Constants for the interrupt and I/O channel control block
//
// Function
// - Connect on idle channel sends 12-bit code with connect enable, skips one word
// - Function select on idle channel sends 12-bit code with function enable, skip one
// - Busy channel: send nothing, continue at next word as reject path
// - Status copy: external status to low 12, mask to high 12 of accumulator
// - External sense: common one bit continues next word, else skip one
// - Internal sense: common one bit continues next word, else skip one
// - Interrupt sense: line and mask both one continues, else skip one
// - Mask selective set sets mask bits where operand is one
// - Mask selective clear clears mask bits where operand is one
// - Enable arms interrupts after one more instruction; disable turns them off
// - Fault clear clears only operand-selected fault indicators
// - Internal status copy loads mask and internal status into accumulator
// - Dedicated operations set float fault and decimal fault logic
// - Eight lines from each of eight channels give 64 maskable sources
// - Lower channel, then lower line, wins; channel 0 line 0 highest
// - Mask bits 00-07 stand for I/O interrupts except for fault clear
// - Channel clear acts on operand bits 00-07, 08 and 11
// - Character input clears accumulator, loads 6-bit character low
// - Word input clears accumulator, loads 12 or 24 bits by channel width
// - Character output sends low six bits, accumulator unchanged
`ifndef IOCC_MAP_VH
`define IOCC_MAP_VH
// ****************************************
// Operation codes
// ****************************************
`define IOCC_OP_CONNECT 5'h01
`define IOCC_OP_FSEL 5'h02
`define IOCC_OP_COPY 5'h03
`define IOCC_OP_XSENSE 5'h04
`define IOCC_OP_ISENSE 5'h05
`define IOCC_OP_IRQSENSE 5'h06
`define IOCC_OP_MSET 5'h07
`define IOCC_OP_MCLR 5'h08
`define IOCC_OP_IRQ_ON 5'h09
`define IOCC_OP_IRQ_OFF 5'h0a
`define IOCC_OP_FCLR 5'h0b
`define IOCC_OP_ICOPY 5'h0c
`define IOCC_OP_DECF 5'h0d
`define IOCC_OP_FLTF 5'h0e
`define IOCC_OP_CHCLR 5'h0f
`define IOCC_OP_CHIN 5'h10
`define IOCC_OP_WDIN 5'h11
`define IOCC_OP_CHOUT 5'h12
`define IOCC_OP_TYIN 5'h13
`define IOCC_OP_TYOUT 5'h14
// ****************************************
// Field positions and values
// ****************************************
`define IOCC_IO_MSB 7
`define IOCC_CLR_SM 8
`define IOCC_CLR_TY 11
`define IOCC_FLT_FP 0
`define IOCC_FLT_BCD 1
`define IOCC_NEXT_P1 2'h1
`define IOCC_NEXT_P2 2'h2
`define IOCC_CHAR_W 6
`define IOCC_HALF_W 12
`define IOCC_FILE_FIRST 6'h13
`define IOCC_FILE_LAST 6'h1b
`define IOCC_MASK_RST 24'h000000
`endif

// [iocc_periph.sv]
// Peripheral controller model on the data side
`timescale 1ns/10ps
`default_nettype none
module iocc_periph (
  input wire logic clk,
  input wire logic rx_ready_r,
  output logic rx_valid,
  output logic [23:0] rx_data,
  input wire logic tx_valid_r,
  input wire logic [5:0] tx_data_r,
  output logic tx_ready
);
  logic [23:0] words[$];
  logic [5:0] got[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 24'h0;
    tx_ready = 1'b0;
  end
  always @(posedge clk) begin
    if (rx_valid && rx_ready_r) begin
      void'(words.pop_front());
    end
    if (tx_valid_r && tx_ready) begin
      got.push_back(tx_data_r);
    end
    #1;
    // Gap after each word, since ready lags the FIFO by a cycle
    rx_valid = !rx_valid && words.size() != 0;
    rx_data = rx_valid ? words[0] : ~rx_data;
    tx_ready = 1'($urandom);
  end
endmodule // iocc_periph
`default_nettype wire

// [iocc_properties.sv]
// Port assertions for the interrupt and channel control block
`timescale 1ns/10ps
`default_nettype none
`include "iocc_map.vh"
module iocc_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic op_valid,
  input wire logic [4:0] op_code,
  input wire logic [23:0] op_operand,
  input wire logic op_done_r,
  input wire logic [1:0] op_next_r,
  input wire logic [7:0] connect_en_r,
  input wire logic [7:0] function_en_r,
  input wire logic tx_valid_r,
  input wire logic tx_ready,
  input wire logic [5:0] tx_data_r,
  input wire logic [23:0] mask_r,
  input wire logic int_enable_r,
  input wire logic int_take_r,
  input wire logic [5:0] int_vector_r
);
  // ****
  // Request tracking
  // ****
  logic busy_r;
  logic busy_nxt;
  // A held level is not a new request while an op runs
  assign busy_nxt = (op_valid && !busy_r) || (busy_r && !op_done_r);
  always @(posedge clk) begin
    busy_r <= !sys_rst && busy_nxt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_take(logic [4:0] c);
    op_valid && !busy_r && op_code == c;
  endsequence
  AST_CONN_SKIP: assert property (|connect_en_r |-> op_done_r && op_next_r == 2'h2)
    else $error("connect without skip of two");
  AST_FSEL_SKIP: assert property (|function_en_r |-> op_done_r && op_next_r == 2'h2)
    else $error("select without skip of two");
  AST_MSET: assert property (s_take(`IOCC_OP_MSET) |-> ##2
    mask_r == ($past(mask_r, 2) | $past(op_operand, 2))) else $error("mask set wrong");
  AST_MCLR: assert property (s_take(`IOCC_OP_MCLR) |-> ##2
    mask_r == ($past(mask_r, 2) & ~$past(op_operand, 2))) else $error("mask clear wrong");
  AST_ARM_LATE: assert property (s_take(`IOCC_OP_IRQ_ON) ##0 !int_enable_r |-> ##2 !int_enable_r)
    else $error("enable armed too early");
  AST_TAKE_DISARM: assert property (int_take_r |=> !int_enable_r)
    else $error("enable kept after take");
  AST_TAKE_ARMED: assert property (int_take_r |-> $past(int_enable_r))
    else $error("take while disarmed");
  AST_TAKE_MASKED: assert property (int_take_r |-> mask_r[int_vector_r[5:3]])
    else $error("take from masked channel");
  AST_TX_HOLD: assert property (tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_data_r))
    else $error("output character dropped");
endmodule // iocc_properties
`default_nettype wire

// [iocc_top.v]
// Interrupt and I/O channel instruction execution logic
`timescale 1ns/10ps
`default_nettype none
`include "iocc_map.vh"
module iocc_top #(
  parameter NCH = 8,
  parameter FDEPTH = 16
) (
  input wire clk,
  input wire sys_rst,
  input wire op_valid,
  input wire [4:0] op_code,
  input wire [2:0] op_chan,
  input wire [23:0] op_operand,
  input wire [23:0] acc_in,
  output reg op_done_r,
  output reg [1:0] op_next_r,
  output reg acc_we_r,
  output reg [23:0] acc_out_r,
  input wire [7:0] chan_busy_pin,
  input wire [95:0] chan_status_pin,
  input wire [7:0] chan_wide_pin,
  input wire [63:0] irq_line_pin,
  input wire [23:0] int_status_pin,
  output reg [11:0] chan_code_r,
  output reg [7:0] connect_en_r,
  output reg [7:0] function_en_r,
  output reg [7:0] chan_clear_r,
  output reg sm_clear_r,
  output reg ty_clear_r,
  output reg ty_start_r,
  output reg ty_dir_out_r,
  output reg [5:0] ty_first_loc_r,
  output reg [5:0] ty_last_loc_r,
  input wire rx_valid,
  output reg rx_ready_r,
  input wire [23:0] rx_data,
  output reg tx_valid_r,
  input wire tx_ready,
  output reg [5:0] tx_data_r,
  output reg [23:0] mask_r,
  output reg int_enable_r,
  output reg int_take_r,
  output reg [5:0] int_vector_r,
  output reg [1:0] fault_r
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg [7:0] busy_s1, busy_s2;
  reg [95:0] stat_s1, stat_s2;
  reg [7:0] wide_s1, wide_s2;
  reg [63:0] irq_s1, irq_s2;
  reg [23:0] ist_s1, ist_s2;
  always @(posedge clk) begin
    busy_s1 <= chan_busy_pin;
    busy_s2 <= busy_s1;
    stat_s1 <= chan_status_pin;
    stat_s2 <= stat_s1;
    wide_s1 <= chan_wide_pin;
    wide_s2 <= wide_s1;
    irq_s1 <= irq_line_pin;
    irq_s2 <= irq_s1;
    ist_s1 <= int_status_pin;
    ist_s2 <= ist_s1;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function [1:0] sense_next;
    input hit;
    begin
      sense_next = hit ? `IOCC_NEXT_P1 : `IOCC_NEXT_P2;
    end
  endfunction

  // One strobe bit per channel, shared by connect and function select
  function [7:0] chan_onehot;
    input [2:0] sel;
    begin
      chan_onehot = 8'h01 << sel;
    end
  endfunction

  // Mask in the upper half, a 12-bit status code in the lower half
  function [23:0] mask_and_status;
    input [23:0] mask;
    input [11:0] stat;
    begin
      mask_and_status = {mask[`IOCC_HALF_W-1:0], stat};
    end
  endfunction

  // Narrow words land low and the rest of the accumulator is cleared
  function [23:0] char_to_acc;
    input [23:0] word;
    begin
      char_to_acc = {{(24-`IOCC_CHAR_W){1'b0}}, word[`IOCC_CHAR_W-1:0]};
    end
  endfunction

  function [23:0] half_to_acc;
    input [23:0] word;
    begin
      half_to_acc = {{(24-`IOCC_HALF_W){1'b0}}, word[`IOCC_HALF_W-1:0]};
    end
  endfunction

  // ****************************************
  // Interrupt priority
  // ****************************************
  // Channel mask gates all eight lines of that channel
  wire [63:0] irq_act;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_act
      assign irq_act[g*8 +: 8] = irq_s2[g*8 +: 8] & {8{mask_r[g]}};
    end
  endgenerate

  reg [5:0] win;
  reg win_hit;
  integer i;
  always @* begin
    win = 6'h00;
    win_hit = 1'b0;
    // Descending scan so the lowest index is left as winner
    for (i = 63; i >= 0; i = i - 1) begin
      if (irq_act[i]) begin
        win = i[5:0];
        win_hit = 1'b1;
      end
    end
  end

  // ****************************************
  // Input FIFO
  // ****************************************
  wire fifo_valid;
  wire [23:0] fifo_data;
  wire fifo_in_ready;
  reg fifo_pop;
  // Take a word only where ready was shown, so source and FIFO agree
  wire rx_take = rx_valid && rx_ready_r;
  iocc_fifo #(.WIDTH(24), .DEPTH(FDEPTH), .AW(4)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(rx_take),
    .in_ready(fifo_in_ready),
    .in_data(rx_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ****************************************
  // Execution state machine
  // ****************************************
  localparam S_IDLE = 3'b001;
  localparam S_RX = 3'b010;
  localparam S_TX = 3'b100;
  reg [2:0] st_r;
  reg wide_op_r;
  reg arm_pend_r;
  reg arm_go_r;
  wire [2:0] ch = op_chan;
  wire [11:0] ch_stat = stat_s2[ch*`IOCC_HALF_W +: `IOCC_HALF_W];
  wire ch_busy = busy_s2[ch];
  wire new_op = op_valid && (st_r == S_IDLE);

  always @* begin
    fifo_pop = (st_r == S_RX) && fifo_valid;
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      st_r <= S_IDLE;
      op_done_r <= 1'b0;
      op_next_r <= 2'h0;
      acc_we_r <= 1'b0;
      acc_out_r <= 24'h000000;
      chan_code_r <= 12'h000;
      connect_en_r <= 8'h00;
      function_en_r <= 8'h00;
      chan_clear_r <= 8'h00;
      sm_clear_r <= 1'b0;
      ty_clear_r <= 1'b0;
      ty_start_r <= 1'b0;
      ty_dir_out_r <= 1'b0;
      ty_first_loc_r <= 6'h00;
      ty_last_loc_r <= 6'h00;
      rx_ready_r <= 1'b0;
      tx_valid_r <= 1'b0;
      tx_data_r <= 6'h00;
      mask_r <= `IOCC_MASK_RST;
      int_enable_r <= 1'b0;
      arm_pend_r <= 1'b0;
      arm_go_r <= 1'b0;
      int_take_r <= 1'b0;
      int_vector_r <= 6'h00;
      fault_r <= 2'h0;
      wide_op_r <= 1'b0;
    end else begin
      op_done_r <= 1'b0;
      acc_we_r <= 1'b0;
      connect_en_r <= 8'h00;
      function_en_r <= 8'h00;
      chan_clear_r <= 8'h00;
      sm_clear_r <= 1'b0;
      ty_clear_r <= 1'b0;
      ty_start_r <= 1'b0;
      int_take_r <= 1'b0;
      // Ready drops a cycle after each word, as the FIFO count lags by one
      rx_ready_r <= fifo_in_ready && !rx_take;
      // Arm only once the op after the enable has finished
      if (arm_go_r && op_done_r) begin
        int_enable_r <= 1'b1;
        arm_go_r <= 1'b0;
      end
      // Interrupt selection only while enabled; a take beats a late arm
      if (int_enable_r && win_hit && !op_valid) begin
        int_take_r <= 1'b1;
        int_vector_r <= win;
        int_enable_r <= 1'b0;
      end
      if (tx_valid_r && tx_ready) begin
        tx_valid_r <= 1'b0;
      end
      case (st_r)
        S_IDLE: begin
          if (new_op) begin
            op_done_r <= 1'b1;
            op_next_r <= `IOCC_NEXT_P1;
            // Deferred arm: enable takes effect once this op completes
            if (arm_pend_r) begin
              arm_go_r <= 1'b1;
              arm_pend_r <= 1'b0;
            end
            case (op_code)
              `IOCC_OP_CONNECT, `IOCC_OP_FSEL: begin
                if (ch_busy) begin
                  op_next_r <= `IOCC_NEXT_P1;
                end else begin
                  chan_code_r <= acc_in[`IOCC_HALF_W-1:0];
                  op_next_r <= `IOCC_NEXT_P2;
                  if (op_code == `IOCC_OP_CONNECT) begin
                    connect_en_r <= chan_onehot(ch);
                  end else begin
                    function_en_r <= chan_onehot(ch);
                  end
                end
              end
              `IOCC_OP_COPY: begin
                acc_we_r <= 1'b1;
                acc_out_r <= mask_and_status(mask_r, ch_stat);
              end
              `IOCC_OP_XSENSE: begin
                op_next_r <= sense_next(|(ch_stat & op_operand[`IOCC_HALF_W-1:0]));
              end
              `IOCC_OP_ISENSE: begin
                op_next_r <= sense_next(|(ist_s2 & op_operand));
              end
              `IOCC_OP_IRQSENSE: begin
                op_next_r <= sense_next(win_hit);
              end
              `IOCC_OP_MSET: begin
                mask_r <= mask_r | op_operand;
              end
              `IOCC_OP_MCLR: begin
                mask_r <= mask_r & ~op_operand;
              end
              `IOCC_OP_IRQ_ON: begin
                arm_pend_r <= 1'b1;
              end
              `IOCC_OP_IRQ_OFF: begin
                int_enable_r <= 1'b0;
                arm_pend_r <= 1'b0;
                arm_go_r <= 1'b0;
              end
              `IOCC_OP_FCLR: begin
                fault_r <= fault_r & ~op_operand[1:0];
              end
              `IOCC_OP_ICOPY: begin
                acc_we_r <= 1'b1;
                acc_out_r <= mask_and_status(mask_r, ist_s2[`IOCC_HALF_W-1:0]);
              end
              `IOCC_OP_DECF: begin
                fault_r[`IOCC_FLT_BCD] <= 1'b1;
              end
              `IOCC_OP_FLTF: begin
                fault_r[`IOCC_FLT_FP] <= 1'b1;
              end
              `IOCC_OP_CHCLR: begin
                chan_clear_r <= op_operand[`IOCC_IO_MSB:0];
                sm_clear_r <= op_operand[`IOCC_CLR_SM];
                ty_clear_r <= op_operand[`IOCC_CLR_TY];
              end
              `IOCC_OP_CHIN, `IOCC_OP_WDIN: begin
                op_done_r <= 1'b0;
                wide_op_r <= (op_code == `IOCC_OP_WDIN);
                st_r <= S_RX;
              end
              `IOCC_OP_CHOUT: begin
                op_done_r <= 1'b0;
                tx_data_r <= acc_in[`IOCC_CHAR_W-1:0];
                tx_valid_r <= 1'b1;
                st_r <= S_TX;
              end
              `IOCC_OP_TYIN, `IOCC_OP_TYOUT: begin
                // Locations must already hold valid addresses
                ty_first_loc_r <= `IOCC_FILE_FIRST;
                ty_last_loc_r <= `IOCC_FILE_LAST;
                ty_dir_out_r <= (op_code == `IOCC_OP_TYOUT);
                ty_start_r <= 1'b1;
              end
              default: begin
                op_next_r <= `IOCC_NEXT_P1;
              end
            endcase
          end
        end
        S_RX: begin
          if (fifo_valid) begin
            acc_we_r <= 1'b1;
            op_done_r <= 1'b1;
            st_r <= S_IDLE;
            if (!wide_op_r) begin
              acc_out_r <= char_to_acc(fifo_data);
            end else if (wide_s2[ch]) begin
              acc_out_r <= fifo_data;
            end else begin
              acc_out_r <= half_to_acc(fifo_data);
            end
          end
        end
        S_TX: begin
          if (tx_ready) begin
            op_done_r <= 1'b1;
            st_r <= S_IDLE;
          end
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule // iocc_top
`default_nettype wire

// [test_interrupt_and_io_channel_control.sv]
// Bench for the interrupt and channel control block
`timescale 1ns/10ps
`default_nettype none
`include "iocc_map.vh"
module test_interrupt_and_io_channel_control;
  logic clk, sys_rst, op_valid, rx_valid, tx_ready, op_done_r, acc_we_r, sm_clear_r, ty_clear_r;
  logic ty_start_r, ty_dir_out_r, rx_ready_r, tx_valid_r, int_enable_r, int_take_r, h;
  logic [1:0] op_next_r, fault_r;
  logic [2:0] op_chan;
  logic [4:0] op_code;
  logic [5:0] ty_first_loc_r, ty_last_loc_r, tx_data_r, int_vector_r;
  logic [7:0] chan_busy_pin, chan_wide_pin, connect_en_r, function_en_r, chan_clear_r;
  logic [11:0] chan_code_r;
  logic [23:0] op_operand, acc_in, acc_out_r, rx_data, int_status_pin, mask_r, x, w, m;
  logic [63:0] irq_line_pin, gate;
  logic [95:0] chan_status_pin;
  logic [23:0] exp_q[$];
  logic [4:0] sense_c[3] = '{`IOCC_OP_XSENSE, `IOCC_OP_ISENSE, `IOCC_OP_IRQSENSE};
  int fails, compares, i, n;
  iocc_top #(.NCH(8), .FDEPTH(16)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_code(op_code), .op_chan(op_chan),
    .op_operand(op_operand), .acc_in(acc_in), .op_done_r(op_done_r), .op_next_r(op_next_r),
    .acc_we_r(acc_we_r), .acc_out_r(acc_out_r), .chan_busy_pin(chan_busy_pin),
    .chan_status_pin(chan_status_pin), .chan_wide_pin(chan_wide_pin),
    .irq_line_pin(irq_line_pin), .int_status_pin(int_status_pin), .chan_code_r(chan_code_r),
    .connect_en_r(connect_en_r), .function_en_r(function_en_r), .chan_clear_r(chan_clear_r),
    .sm_clear_r(sm_clear_r), .ty_clear_r(ty_clear_r), .ty_start_r(ty_start_r),
    .ty_dir_out_r(ty_dir_out_r), .ty_first_loc_r(ty_first_loc_r), .ty_last_loc_r(ty_last_loc_r),
    .rx_valid(rx_valid), .rx_ready_r(rx_ready_r), .rx_data(rx_data), .tx_valid_r(tx_valid_r),
    .tx_ready(tx_ready), .tx_data_r(tx_data_r), .mask_r(mask_r), .int_enable_r(int_enable_r),
    .int_take_r(int_take_r), .int_vector_r(int_vector_r), .fault_r(fault_r));
  iocc_periph periph_u (.clk(clk), .rx_ready_r(rx_ready_r), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid_r(tx_valid_r), .tx_data_r(tx_data_r), .tx_ready(tx_ready));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One-cycle request, then wait for completion
  task automatic run_op(input logic [4:0] c, input logic [2:0] ch, input logic [23:0] v);
    @(posedge clk);
    #1;
    {op_code, op_chan, op_operand, op_valid} = {c, ch, v, 1'b1};
    @(posedge clk);
    #1;
    op_valid = 1'b0;
    n = 0;
    while (op_done_r !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 300) begin
      fails++;
      close_out;
    end
  endtask
  initial begin
    #400000;
    fails++;
    close_out;
  end
  initial begin
    void'($urandom(27));
    {op_valid, op_code, op_chan, op_operand, acc_in, chan_busy_pin, chan_wide_pin} = '0;
    {irq_line_pin, int_status_pin, chan_status_pin} = '0;
    {fails, compares, m, sys_rst} = {32'h0, 32'h0, 24'h0, 1'b1};
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    chk({fault_r, int_enable_r, mask_r[20:0]}, 24'h0);
    {chan_wide_pin, int_status_pin} = 32'($urandom);
    chan_status_pin = {$urandom, $urandom, $urandom};
    for (i = 0; i < 4; i++) begin
      {w, acc_in} = {24'($urandom), 24'($urandom)};
      chan_busy_pin = (8'h01 << w[2:0]) ^ (i > 1 ? 8'h00 : 8'hff);
      repeat (2) @(posedge clk);
      run_op(i[0] ? `IOCC_OP_FSEL : `IOCC_OP_CONNECT, w[2:0], 24'h0);
      chk(op_next_r, i > 1 ? 24'h1 : 24'h2);
      chk(connect_en_r, i == 0 ? 8'h01 << w[2:0] : 8'h00);
      chk(function_en_r, i == 1 ? 8'h01 << w[2:0] : 8'h00);
      if (i < 2) chk(chan_code_r, acc_in[11:0]);
    end
    for (i = 0; i < 6; i++) begin
      x = 24'($urandom);
      run_op(i[0] ? `IOCC_OP_MCLR : `IOCC_OP_MSET, 3'h0, x);
      m = i[0] ? m & ~x : m | x;
      chk(mask_r, m);
    end
    irq_line_pin = {$urandom, $urandom} & {$urandom, $urandom};
    for (i = 0; i < 64; i++) gate[i] = m[i / 8];
    for (i = 0; i < 12; i++) begin
      {x, w} = {24'($urandom & $urandom & $urandom), 24'($urandom % 8)};
      h = i % 3 == 0 ? |(chan_status_pin[w * 12 +: 12] & x[11:0]) :
        i % 3 == 1 ? |(int_status_pin & x) : |(irq_line_pin & gate);
      run_op(sense_c[i % 3], w[2:0], x);
      chk(op_next_r, h ? 24'h1 : 24'h2);
    end
    run_op(`IOCC_OP_COPY, 3'h5, 24'h0);
    chk({acc_we_r, acc_out_r[22:0]}, {1'b1, m[10:0], chan_status_pin[71:60]});
    run_op(`IOCC_OP_ICOPY, 3'h0, 24'h0);
    chk(acc_out_r, {m[11:0], int_status_pin[11:0]});
    run_op(`IOCC_OP_DECF, 3'h0, 24'h0);
    chk(fault_r, 24'h2);
    run_op(`IOCC_OP_FLTF, 3'h0, 24'h0);
    chk(fault_r, 24'h3);
    run_op(`IOCC_OP_FCLR, 3'h0, 24'h1);
    chk(fault_r, 24'h2);
    run_op(`IOCC_OP_FCLR, 3'h0, 24'h2);
    chk(fault_r, 24'h0);
    run_op(`IOCC_OP_CHCLR, 3'h0, 24'h000905);
    chk({ty_clear_r, sm_clear_r, chan_clear_r}, 24'h305);
    for (i = 0; i < 2; i++) begin
      run_op(i ? `IOCC_OP_TYOUT : `IOCC_OP_TYIN, 3'h0, 24'h0);
      chk({ty_start_r, ty_dir_out_r, ty_first_loc_r, ty_last_loc_r}, {1'b1, i[0], 12'h4db});
    end
    for (i = 0; i < 3; i++) begin
      acc_in = 24'($urandom);
      run_op(`IOCC_OP_CHOUT, 3'h0, 24'h0);
      chk({acc_we_r, periph_u.got.pop_front()}, {1'b0, acc_in[5:0]});
    end
    // Overfill so the FIFO must refuse
    for (i = 0; i < 18; i++) begin
      w = 24'($urandom);
      periph_u.words.push_back(w);
      exp_q.push_back(w);
    end
    repeat (80) @(posedge clk);
    #1;
    chk(rx_ready_r, 24'h0);
    for (i = 0; i < 18; i++) begin
      w = exp_q.pop_front();
      run_op(i[0] ? `IOCC_OP_WDIN : `IOCC_OP_CHIN, 3'h0, 24'h0);
      chk(acc_out_r, !i[0] ? {18'h0, w[5:0]} : chan_wide_pin[0] ? w : {12'h0, w[11:0]});
    end
    run_op(`IOCC_OP_MCLR, 3'h0, 24'hffffff);
    run_op(`IOCC_OP_MSET, 3'h0, 24'h000006);
    irq_line_pin = 64'h200801;
    repeat (2) @(posedge clk);
    run_op(`IOCC_OP_IRQ_ON, 3'h0, 24'h0);
    chk(int_enable_r, 24'h0);
    run_op(`IOCC_OP_MSET, 3'h0, 24'h000006);
    for (i = 0; i < 20 && int_take_r !== 1'b1; i++) @(posedge clk) #1;
    chk(int_vector_r, 24'h0b);
    close_out;
  end
endmodule // test_interrupt_and_io_channel_control
bind iocc_top iocc_properties chk_u (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid),
  .op_code(op_code), .op_operand(op_operand), .op_done_r(op_done_r), .op_next_r(op_next_r),
  .connect_en_r(connect_en_r), .function_en_r(function_en_r), .tx_valid_r(tx_valid_r),
  .tx_ready(tx_ready), .tx_data_r(tx_data_r), .mask_r(mask_r), .int_enable_r(int_enable_r),
  .int_take_r(int_take_r), .int_vector_r(int_vector_r));
`default_nettype wire
